// [pkg/ulm_pkg.sv]
// register map, field positions and framing constants
// assumes a 32-bit classic wishbone slave port
`default_nettype none
package ulm_pkg;
  // ==========================================
  // register byte addresses
  localparam logic [31:0] ADR_DATA = 32'h4000_8000;
  localparam logic [31:0] ADR_DIVH = 32'h4000_8004;
  localparam logic [31:0] ADR_LFC = 32'h4000_800C;
  localparam logic [31:0] ADR_MLC = 32'h4000_8010;
  localparam logic [31:0] ADR_LST = 32'h4000_8014;
  localparam logic [31:0] ADR_MST = 32'h4000_8018;
  // ==========================================
  // line_format_control fields
  localparam int LFC_STOP = 2;
  localparam int LFC_PEN = 3;
  localparam int LFC_BRK = 6;
  localparam int LFC_DIV = 7;
  localparam logic [7:0] LFC_RST = 8'h00;
  // ==========================================
  // modem_line_control fields
  localparam int MLC_DTR = 0;
  localparam int MLC_RTS = 1;
  localparam int MLC_OUT1 = 2;
  localparam int MLC_OUT2 = 3;
  localparam int MLC_LOOP = 4;
  localparam int MLC_ARTS = 6;
  localparam int MLC_ACTS = 7;
  localparam logic [7:0] MLC_RST = 8'h00;
  localparam logic [7:0] MLC_WMASK = 8'hDF;
  localparam logic [7:0] MLC_LOOP_RMASK = 8'hFC;
  // ==========================================
  // line status bits
  localparam int LST_RDY = 0;
  localparam int LST_OVR = 1;
  localparam int LST_PERR = 2;
  localparam int LST_FERR = 3;
  localparam int LST_THRE = 5;
  localparam int LST_TEMT = 6;
  // ==========================================
  // parity kinds and framing
  localparam logic [1:0] PAR_ODD = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ONE = 2'h2;
  localparam logic [1:0] PAR_ZERO = 2'h3;
  localparam logic [1:0] LEN_5 = 2'h0;
  localparam logic [1:0] LEN_8 = 2'h3;
  localparam logic [2:0] FIRST_LAST_BIT = 3'h4;
  localparam logic [3:0] OVS_LAST = 4'hF;
  localparam logic [3:0] HALF_LAST = 4'h7;
  localparam logic [5:0] STOP1_LAST = 6'h0F;
  localparam logic [5:0] STOP15_LAST = 6'h17;
  localparam logic [5:0] STOP2_LAST = 6'h1F;
  localparam logic [4:0] PIN_IDLE = 5'h1F;

  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] len,
                                   input logic [1:0] kind);
    logic x;
    x = ^(d & (8'hFF >> (LEN_8 - len)));
    unique case (kind)
      PAR_ODD: par_bit = ~x;
      PAR_EVEN: par_bit = x;
      PAR_ONE: par_bit = 1'b1;
      PAR_ZERO: par_bit = 1'b0;
    endcase
  endfunction
endpackage
`default_nettype wire

// [hw/ulm_tx.sv]
// serial character transmitter driven by a 16x bit tick
// assumes start is only raised while busy is low
`default_nettype none
module ulm_tx (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  // character request
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  // format
  input wire logic [1:0] len,
  input wire logic two_stop,
  input wire logic pen,
  input wire logic [1:0] pkind,
  // serial line
  output logic ser
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_START = 5'b00010,
    S_DATA = 5'b00100,
    S_PAR = 5'b01000,
    S_STOP = 5'b10000
  } ulm_txst_t;

  ulm_txst_t state_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;
  logic [5:0] tcnt_reg;
  logic par_reg;
  logic ser_reg;
  logic [2:0] last_bit;
  logic [5:0] stop_last;
  logic bit_end;

  assign last_bit = ulm_pkg::FIRST_LAST_BIT + {1'b0, len};
  assign stop_last = !two_stop ? ulm_pkg::STOP1_LAST :
    (len == ulm_pkg::LEN_5) ? ulm_pkg::STOP15_LAST : ulm_pkg::STOP2_LAST;
  assign bit_end = tick && (tcnt_reg[3:0] == ulm_pkg::OVS_LAST);
  assign busy = !state_reg[0];
  assign ser = ser_reg;

  // ==========================================
  // framing sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 3'h0;
      tcnt_reg <= 6'h00;
      par_reg <= 1'b0;
      ser_reg <= 1'b1;
    end else begin
      if (tick) begin
        tcnt_reg <= tcnt_reg + 6'h01;
      end
      unique case (state_reg)
        S_IDLE: if (start) begin
          shift_reg <= data;
          par_reg <= ulm_pkg::par_bit(data, len, pkind);
          ser_reg <= 1'b0;
          tcnt_reg <= 6'h00;
          state_reg <= S_START;
        end
        S_START: if (bit_end) begin
          tcnt_reg <= 6'h00;
          bit_reg <= 3'h0;
          ser_reg <= shift_reg[0];
          state_reg <= S_DATA;
        end
        S_DATA: if (bit_end) begin
          tcnt_reg <= 6'h00;
          bit_reg <= bit_reg + 3'h1;
          shift_reg <= shift_reg >> 1;
          ser_reg <= shift_reg[1];
          if (bit_reg == last_bit) begin
            ser_reg <= pen ? par_reg : 1'b1;
            state_reg <= pen ? S_PAR : S_STOP;
          end
        end
        S_PAR: if (bit_end) begin
          tcnt_reg <= 6'h00;
          ser_reg <= 1'b1;
          state_reg <= S_STOP;
        end
        S_STOP: if (tick && tcnt_reg == stop_last) begin
          tcnt_reg <= 6'h00;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [hw/ulm_line_modem.sv]
// line format and modem control block of a 16550-style uart
// assumes a classic wishbone master on the system clock, pins asynchronous
`default_nettype none
module ulm_line_modem #(
  parameter logic [15:0] DIV_RST = 16'h0001
) (
  // system
  input wire logic CLK_SYS,
  input wire logic RST,
  // wishbone slave
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [31:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  // serial data
  input wire logic RXD,
  output logic TXD,
  // modem lines, active low
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic DCD_N,
  output logic RTS_N,
  output logic DTR_N
);
  typedef enum logic [4:0] {
    R_IDLE = 5'b00001,
    R_START = 5'b00010,
    R_DATA = 5'b00100,
    R_PAR = 5'b01000,
    R_STOP = 5'b10000
  } ulm_rxst_t;

  // ==========================================
  // pin synchronisers
  logic [4:0] pin_raw;
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] sync3_reg;
  logic [4:0] pin_reg;

  assign pin_raw = {DCD_N, RI_N, DSR_N, CTS_N, RXD};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          sync1_reg[gi] <= 1'b1;
          sync2_reg[gi] <= 1'b1;
          sync3_reg[gi] <= 1'b1;
          pin_reg[gi] <= 1'b1;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          // a change counts only once two stages agree
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            pin_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================
  // registers
  logic [7:0] lfc_reg;
  logic [7:0] mlc_reg;
  logic [15:0] div_reg;
  logic [15:0] baud_reg;
  logic [7:0] thr_reg;
  logic thr_full_reg;
  logic [7:0] rbuf_reg;
  logic rdy_reg;
  logic ovr_reg;
  logic perr_reg;
  logic ferr_reg;
  logic [3:0] lvl_reg;
  logic [3:0] delta_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic txd_reg;
  logic rts_n_reg;
  logic dtr_n_reg;

  // format fields
  logic [1:0] len;
  logic [1:0] pkind;
  logic pen;
  logic divisor_access;
  logic loop;

  assign len = lfc_reg[1:0];
  assign pen = lfc_reg[ulm_pkg::LFC_PEN];
  assign pkind = lfc_reg[5:4];
  assign divisor_access = lfc_reg[ulm_pkg::LFC_DIV];
  assign loop = mlc_reg[ulm_pkg::MLC_LOOP];

  // ==========================================
  // bus decode
  logic req;
  logic wr;
  logic rd;
  logic hit_data;
  logic hit_divh;
  logic hit_lfc;
  logic hit_mlc;
  logic hit_lst;
  logic hit_mst;

  assign req = CYC_I && STB_I && !ack_reg;
  assign wr = req && WE_I && SEL_I[0];
  assign rd = req && !WE_I;
  assign hit_data = ADR_I == ulm_pkg::ADR_DATA;
  assign hit_divh = ADR_I == ulm_pkg::ADR_DIVH;
  assign hit_lfc = ADR_I == ulm_pkg::ADR_LFC;
  assign hit_mlc = ADR_I == ulm_pkg::ADR_MLC;
  assign hit_lst = ADR_I == ulm_pkg::ADR_LST;
  assign hit_mst = ADR_I == ulm_pkg::ADR_MST;

  logic wr_divl;
  logic wr_divh;
  logic wr_thr;
  logic rd_rbuf;
  logic rd_lst;
  logic rd_mst;

  assign wr_divl = wr && hit_data && divisor_access;
  assign wr_divh = wr && hit_divh && divisor_access;
  assign wr_thr = wr && hit_data && !divisor_access;
  assign rd_rbuf = rd && hit_data && !divisor_access;
  assign rd_lst = rd && hit_lst;
  assign rd_mst = rd && hit_mst;

  // ==========================================
  // modem status
  logic [3:0] lvl_ext;
  logic [3:0] lvl_loop;
  logic [3:0] lvl;
  logic [3:0] lvl_evt;

  // order is {dcd, ri, dsr, cts}, active high
  assign lvl_ext = ~pin_reg[4:1];
  assign lvl_loop = {mlc_reg[ulm_pkg::MLC_OUT2], mlc_reg[ulm_pkg::MLC_OUT1],
                     mlc_reg[ulm_pkg::MLC_DTR], mlc_reg[ulm_pkg::MLC_RTS]};
  assign lvl = loop ? lvl_loop : lvl_ext;
  // ri reports its trailing edge only
  assign lvl_evt = {lvl_reg[3] ^ lvl[3], lvl_reg[2] & ~lvl[2],
                    lvl_reg[1] ^ lvl[1], lvl_reg[0] ^ lvl[0]};

  // ==========================================
  // read mux
  logic [7:0] lst;
  logic [7:0] mlc_rd;
  logic [7:0] rdat;
  logic tx_busy;

  assign lst = {1'b0, !thr_full_reg && !tx_busy, !thr_full_reg, 1'b0,
                ferr_reg, perr_reg, ovr_reg, rdy_reg};
  assign mlc_rd = loop ? (mlc_reg & ulm_pkg::MLC_LOOP_RMASK) : mlc_reg;
  assign rdat = hit_data ? (divisor_access ? div_reg[7:0] : rbuf_reg) :
    hit_divh ? (divisor_access ? div_reg[15:8] : 8'h00) :
    hit_lfc ? lfc_reg :
    hit_mlc ? mlc_rd :
    hit_lst ? lst :
    hit_mst ? {lvl, delta_reg} : 8'h00;

  // ==========================================
  // bit-rate tick
  logic [15:0] div_last;
  logic tick;

  // a zero divisor runs as one rather than stalling
  assign div_last = (div_reg == 16'h0000) ? 16'h0000 : div_reg - 16'h0001;
  assign tick = baud_reg >= div_last;

  // ==========================================
  // transmitter
  logic cts_ok;
  logic tx_start;
  logic tx_ser;
  logic line_int;

  assign cts_ok = !mlc_reg[ulm_pkg::MLC_ACTS] || lvl[0];
  assign tx_start = thr_full_reg && !tx_busy && cts_ok;
  assign line_int = lfc_reg[ulm_pkg::LFC_BRK] ? 1'b0 : tx_ser;

  ulm_tx u_tx (
    .clk(CLK_SYS),
    .rst(RST),
    .tick(tick),
    .start(tx_start),
    .data(thr_reg),
    .busy(tx_busy),
    .len(len),
    .two_stop(lfc_reg[ulm_pkg::LFC_STOP]),
    .pen(pen),
    .pkind(pkind),
    .ser(tx_ser)
  );

  // ==========================================
  // receiver
  ulm_rxst_t rst_reg;
  logic [3:0] rtick_reg;
  logic [2:0] rbit_reg;
  logic [7:0] rshift_reg;
  logic rperr_reg;
  logic rx_in;
  logic [7:0] rx_data;
  logic [2:0] rlast_bit;
  logic rbit_end;
  logic rx_done;

  assign rx_in = loop ? line_int : pin_reg[0];
  assign rx_data = rshift_reg >> (ulm_pkg::LEN_8 - len);
  assign rlast_bit = ulm_pkg::FIRST_LAST_BIT + {1'b0, len};
  assign rbit_end = tick && (rtick_reg == ulm_pkg::OVS_LAST);
  // only the first stop bit is checked
  assign rx_done = (rst_reg == R_STOP) && rbit_end;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rst_reg <= R_IDLE;
      rtick_reg <= 4'h0;
      rbit_reg <= 3'h0;
      rshift_reg <= 8'h00;
      rperr_reg <= 1'b0;
    end else begin
      if (tick) begin
        rtick_reg <= rtick_reg + 4'h1;
      end
      unique case (rst_reg)
        R_IDLE: if (!rx_in) begin
          rtick_reg <= 4'h0;
          rperr_reg <= 1'b0;
          rst_reg <= R_START;
        end
        R_START: if (tick && rtick_reg == ulm_pkg::HALF_LAST) begin
          // a glitch shorter than half a bit is dropped
          rtick_reg <= 4'h0;
          rbit_reg <= 3'h0;
          rst_reg <= rx_in ? R_IDLE : R_DATA;
        end
        R_DATA: if (rbit_end) begin
          rshift_reg <= {rx_in, rshift_reg[7:1]};
          rbit_reg <= rbit_reg + 3'h1;
          if (rbit_reg == rlast_bit) begin
            rst_reg <= pen ? R_PAR : R_STOP;
          end
        end
        R_PAR: if (rbit_end) begin
          rperr_reg <= rx_in != ulm_pkg::par_bit(rx_data, len, pkind);
          rst_reg <= R_STOP;
        end
        R_STOP: if (rbit_end) begin
          rst_reg <= R_IDLE;
        end
        default: rst_reg <= R_IDLE;
      endcase
    end
  end

  // ==========================================
  // control registers and bus answer
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      lfc_reg <= ulm_pkg::LFC_RST;
      mlc_reg <= ulm_pkg::MLC_RST;
      div_reg <= DIV_RST;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      dat_reg <= rd ? {24'h00_0000, rdat} : 32'h0000_0000;
      if (wr && hit_lfc) begin
        lfc_reg <= DAT_I[7:0];
      end
      if (wr && hit_mlc) begin
        mlc_reg <= DAT_I[7:0] & ulm_pkg::MLC_WMASK;
      end
      if (wr_divl) begin
        div_reg[7:0] <= DAT_I[7:0];
      end
      if (wr_divh) begin
        div_reg[15:8] <= DAT_I[7:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      baud_reg <= 16'h0000;
    end else begin
      baud_reg <= tick ? 16'h0000 : baud_reg + 16'h0001;
    end
  end

  // ==========================================
  // holding buffers and sticky flags
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      thr_reg <= 8'h00;
      thr_full_reg <= 1'b0;
      rbuf_reg <= 8'h00;
      rdy_reg <= 1'b0;
      ovr_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      if (wr_thr) begin
        thr_reg <= DAT_I[7:0];
        thr_full_reg <= 1'b1;
      end else if (tx_start) begin
        thr_full_reg <= 1'b0;
      end
      // a new character wins over a read in the same cycle
      if (rx_done) begin
        rbuf_reg <= rx_data;
        rdy_reg <= 1'b1;
      end else if (rd_rbuf) begin
        rdy_reg <= 1'b0;
      end
      ovr_reg <= (ovr_reg && !rd_lst) || (rx_done && rdy_reg);
      perr_reg <= (perr_reg && !rd_lst) || (rx_done && pen && rperr_reg);
      ferr_reg <= (ferr_reg && !rd_lst) || (rx_done && !rx_in);
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      lvl_reg <= 4'h0;
      delta_reg <= 4'h0;
    end else begin
      lvl_reg <= lvl;
      // loopback writes raise deltas like pin changes
      delta_reg <= (delta_reg & ~{4{rd_mst}}) | lvl_evt;
    end
  end

  // ==========================================
  // pin drivers
  logic rts_on;

  assign rts_on = mlc_reg[ulm_pkg::MLC_ARTS] ? !rdy_reg : mlc_reg[ulm_pkg::MLC_RTS];

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      txd_reg <= 1'b1;
      rts_n_reg <= 1'b1;
      dtr_n_reg <= 1'b1;
    end else begin
      txd_reg <= loop ? 1'b1 : line_int;
      rts_n_reg <= loop ? 1'b1 : !rts_on;
      dtr_n_reg <= loop ? 1'b1 : !mlc_reg[ulm_pkg::MLC_DTR];
    end
  end

  assign ACK_O = ack_reg;
  assign DAT_O = dat_reg;
  assign TXD = txd_reg;
  assign RTS_N = rts_n_reg;
  assign DTR_N = dtr_n_reg;
endmodule
`default_nettype wire

// [test/ulm_line_modem_asserts.sv]
// bus handshake and pin level checks for the line format / modem block
// assumes a master that holds each request until the edge where ack is high
`default_nettype none
module ulm_line_modem_asserts (
  // system
  input wire logic CLK_SYS,
  input wire logic RST,
  // wishbone
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [31:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O,
  // serial and modem pins
  input wire logic RXD,
  input wire logic TXD,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic DCD_N,
  input wire logic RTS_N,
  input wire logic DTR_N
);
  // ==========================================
  // shadow copies, one cycle behind the design
  logic [7:0] lfc_sh;
  logic [7:0] mlc_sh;
  logic wr_go;
  logic rd_go;
  assign wr_go = ACK_O && CYC_I && STB_I && WE_I && SEL_I[0];
  assign rd_go = ACK_O && CYC_I && STB_I && !WE_I;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      lfc_sh <= 8'h00;
      mlc_sh <= 8'h00;
    end else if (wr_go && ADR_I == ulm_pkg::ADR_LFC) begin
      lfc_sh <= DAT_I[7:0];
    end else if (wr_go && ADR_I == ulm_pkg::ADR_MLC) begin
      mlc_sh <= DAT_I[7:0] & ulm_pkg::MLC_WMASK;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  a_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
  a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I)) else $error("ack without request");
  a_dat_quiet: assert property (DAT_O[31:8] == 24'h0 && (ACK_O || DAT_O == 32'h0)) else $error("stray read data");
  a_lfc_read: assert property (rd_go && ADR_I == ulm_pkg::ADR_LFC |-> DAT_O[7:0] == lfc_sh)
    else $error("format readback wrong");
  a_mlc_read: assert property (rd_go && ADR_I == ulm_pkg::ADR_MLC |->
    DAT_O[7:0] == (mlc_sh & (mlc_sh[4] ? ulm_pkg::MLC_LOOP_RMASK : 8'hFF))) else $error("modem readback wrong");
  a_divh_hidden: assert property (rd_go && ADR_I == ulm_pkg::ADR_DIVH && !lfc_sh[7] |-> DAT_O == 32'h0)
    else $error("divisor visible");
  a_break_low: assert property (lfc_sh[6] && !mlc_sh[4] && $stable(lfc_sh) && $stable(mlc_sh) |-> !TXD)
    else $error("break not low");
  a_loop_mark: assert property (mlc_sh[4] && $stable(mlc_sh) |-> TXD && RTS_N && DTR_N)
    else $error("loopback pins active");
  a_dtr_pin: assert property (!mlc_sh[4] && $stable(mlc_sh) |-> DTR_N == !mlc_sh[0])
    else $error("dtr pin wrong");
  a_rts_pin: assert property (!mlc_sh[4] && !mlc_sh[6] && $stable(mlc_sh) |-> RTS_N == !mlc_sh[1])
    else $error("rts pin wrong");
endmodule
bind ulm_line_modem ulm_line_modem_asserts ulm_line_modem_asserts_i (.CLK_SYS, .RST, .CYC_I, .STB_I, .WE_I,
  .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .RXD, .TXD, .CTS_N, .DSR_N, .RI_N, .DCD_N, .RTS_N, .DTR_N);
`default_nettype wire

// [test/ulm_modem_model.sv]
// far-side modem: drives receive data and modem inputs, samples the transmit pin
// assumes divisor 1, so one bit lasts 16 clocks
`default_nettype none
module ulm_modem_model (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic txd,
  output logic rxd,
  // modem inputs, active low: dcd ri dsr cts
  output logic [3:0] mdm_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    rxd = 1'b1;
    mdm_n = 4'hF;
  end
  task automatic set_lines(input logic r, input logic [3:0] m);
    @(posedge clk);
    rxd <= r;
    mdm_n <= m;
  endtask
  // start bit, then n bits lsb first; the last ones are the stop bits
  task automatic send(input logic [10:0] bits, input int n);
    int i;
    @(posedge clk);
    rxd <= 1'b0;
    for (i = 0; i < n; i++) begin
      repeat (16) @(posedge clk);
      rxd <= bits[i];
    end
    repeat (16) @(posedge clk);
  endtask
  // samples mid-bit; b[0] is the start bit
  task automatic recv(input int n, input int lim, output logic [11:0] b, output logic ok);
    int i;
    b = 12'h0;
    ok = 1'b0;
    for (i = 0; i < lim && !ok; i++) begin
      @(posedge clk);
      ok = (txd === 1'b0);
    end
    if (ok) begin
      repeat (8) @(posedge clk);
      b[0] = txd;
      for (i = 1; i <= n; i++) begin
        repeat (16) @(posedge clk);
        b[i] = txd;
      end
    end
  endtask
endmodule
`default_nettype wire

// [test/ulm_line_modem_tb_top.sv]
// register-level regression of the line format / modem block
// assumes divisor reset value 1 and a 10 MHz clock
`default_nettype none
module ulm_line_modem_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, cyc, stb, we, txd, ack, rts_n, dtr_n, rxd, ok;
  logic [31:0] adr, dat_w, dat_r, q;
  logic [3:0] sel, mdm_n;
  logic [11:0] b;
  logic [7:0] lf;
  int fail_count, compares, l, k, i;
  ulm_line_modem #(.DIV_RST(16'h0001)) ulm_line_modem_i (.CLK_SYS(clk), .RST(rst), .CYC_I(cyc), .STB_I(stb),
    .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r), .ACK_O(ack), .RXD(rxd), .TXD(txd),
    .CTS_N(mdm_n[0]), .DSR_N(mdm_n[1]), .RI_N(mdm_n[2]), .DCD_N(mdm_n[3]), .RTS_N(rts_n), .DTR_N(dtr_n));
  ulm_modem_model ulm_modem_model_i (.clk(clk), .txd(txd), .rxd(rxd), .mdm_n(mdm_n));
  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [31:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, 24'h0, d, 4'hF};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_r;
    chk("ack", {31'h0, ack}, 32'h1);
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 8'h00);
    chk(nm, q, e);
  endtask
  function automatic logic pexp(input logic [7:0] d, input int l, input int k);
    logic x;
    x = ^(d & (8'hFF >> (3 - l)));
    case (k)
      0: return ~x;
      1: return x;
      2: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  task automatic frame(input logic [7:0] d, input int nd, input int np, input logic pv, input string nm);
    int j;
    logic [11:0] e;
    logic [11:0] m;
    e = 12'h0;
    for (j = 0; j < nd; j++) e[j + 1] = d[j];
    if (np > 0) e[nd + 1] = pv;
    e[nd + np + 1] = 1'b1;
    m = (12'h1 << (nd + np + 2)) - 12'h1;
    ulm_modem_model_i.recv(nd + np + 1, 600, b, ok);
    chk({nm, " start"}, {31'h0, ok}, 32'h1);
    chk(nm, {20'h0, b & m}, {20'h0, e});
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #4_000_000;
    fail_count++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    {rst, cyc, stb, we, adr, dat_w, sel} = {4'h8, 68'h0};
    fail_count = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(ulm_pkg::ADR_LFC, 32'h0, "lfc reset");
    rd(ulm_pkg::ADR_MLC, 32'h0, "mlc reset");
    rd(32'h4000_8020, 32'h0, "unmapped");
    $display("test reset done");
    for (l = 0; l < 4; l++) begin
      for (k = 0; k < 4; k++) begin
        lf = {2'b00, k[1:0], 1'b1, ~l[1], l[1:0]};
        wb(1'b1, ulm_pkg::ADR_LFC, lf);
        rd(ulm_pkg::ADR_LFC, {24'h0, lf}, "lfc");
        wb(1'b1, ulm_pkg::ADR_DATA, 8'h96 ^ lf);
        frame(8'h96 ^ lf, l + 5, 1, pexp(8'h96 ^ lf, l, k), "format frame");
        // two reads straddle the end of a 1.5 bit stop; a 1 bit stop ends before both, a 2 bit stop after both
        repeat (12) @(posedge clk);
        wb(1'b0, ulm_pkg::ADR_LST, 8'h00);
        chk("stop one", {31'h0, q[6]}, {31'h0, l[1]});
        wb(1'b0, ulm_pkg::ADR_LST, 8'h00);
        chk("stop half", {31'h0, q[6]}, {31'h0, l != 1});
        repeat (20) @(posedge clk);
      end
    end
    $display("test formats done");
    wb(1'b1, ulm_pkg::ADR_LFC, 8'h3B);
    for (i = 0; i < 2; i++) begin
      ulm_modem_model_i.send({1'b1, i[0], 8'h5A}, 10);
      repeat (10) @(posedge clk);
      wb(1'b0, ulm_pkg::ADR_LST, 8'h00);
      chk("rx parity", {30'h0, q[2], q[0]}, {30'h0, i[0], 1'b1});
      rd(ulm_pkg::ADR_DATA, 32'h5A, "rx data");
    end
    wb(1'b1, ulm_pkg::ADR_LFC, 8'h43);
    repeat (4) @(posedge clk);
    chk("break", {31'h0, txd}, 32'h0);
    wb(1'b1, ulm_pkg::ADR_LFC, 8'h83);
    wb(1'b1, ulm_pkg::ADR_DIVH, 8'h5A);
    rd(ulm_pkg::ADR_DIVH, 32'h5A, "div high");
    wb(1'b1, ulm_pkg::ADR_DIVH, 8'h00);
    wb(1'b1, ulm_pkg::ADR_DATA, 8'h01);
    repeat (20) @(posedge clk);
    chk("no tx on divisor", {31'h0, txd}, 32'h1);
    rd(ulm_pkg::ADR_DATA, 32'h01, "div low");
    wb(1'b1, ulm_pkg::ADR_LFC, 8'h03);
    rd(ulm_pkg::ADR_DIVH, 32'h0, "div hidden");
    $display("test rx break divisor done");
    wb(1'b1, ulm_pkg::ADR_MLC, 8'h03);
    repeat (6) @(posedge clk);
    chk("dtr rts on", {30'h0, dtr_n, rts_n}, 32'h0);
    ulm_modem_model_i.set_lines(1'b1, 4'b1010);
    repeat (8) @(posedge clk);
    wb(1'b0, ulm_pkg::ADR_MST, 8'h00);
    chk("status pins", {24'h0, q[7:0]}, 32'h51);
    wb(1'b1, ulm_pkg::ADR_MLC, 8'h13);
    ulm_modem_model_i.set_lines(1'b0, 4'h0);
    repeat (6) @(posedge clk);
    chk("loop pins", {29'h0, txd, dtr_n, rts_n}, 32'h7);
    rd(ulm_pkg::ADR_MLC, 32'h10, "loop mlc");
    wb(1'b0, ulm_pkg::ADR_MST, 8'h00);
    // loop levels replace the pins: ri trailing edge and dsr rise show as deltas
    chk("loop status", {24'h0, q[7:0]}, 32'h36);
    wb(1'b1, ulm_pkg::ADR_DATA, 8'hA5);
    repeat (200) @(posedge clk);
    rd(ulm_pkg::ADR_DATA, 32'hA5, "loop data");
    ulm_modem_model_i.set_lines(1'b1, 4'h0);
    wb(1'b1, ulm_pkg::ADR_MLC, 8'h00);
    repeat (8) @(posedge clk);
    wb(1'b0, ulm_pkg::ADR_MST, 8'h00);
    chk("loop off status", {24'h0, q[7:0]}, 32'hF8);
    $display("test modem loopback done");
    wb(1'b1, ulm_pkg::ADR_MLC, 8'h80);
    ulm_modem_model_i.set_lines(1'b1, 4'hF);
    repeat (8) @(posedge clk);
    wb(1'b1, ulm_pkg::ADR_DATA, 8'hC3);
    ulm_modem_model_i.recv(9, 150, b, ok);
    chk("cts hold", {31'h0, ok}, 32'h0);
    ulm_modem_model_i.set_lines(1'b1, 4'hE);
    frame(8'hC3, 8, 0, 1'b0, "cts frame");
    wb(1'b1, ulm_pkg::ADR_MLC, 8'h40);
    repeat (6) @(posedge clk);
    chk("auto rts", {31'h0, rts_n}, 32'h0);
    ulm_modem_model_i.send({2'b11, 1'b1, 8'h3C}, 9);
    repeat (10) @(posedge clk);
    chk("auto rts full", {31'h0, rts_n}, 32'h1);
    rd(ulm_pkg::ADR_DATA, 32'h3C, "auto rts data");
    repeat (6) @(posedge clk);
    chk("auto rts empty", {31'h0, rts_n}, 32'h0);
    $display("test flow control done");
    stop_test();
  end
endmodule
`default_nettype wire
